// ---- hw/seq_fwd_device.sv ----
`timescale 1ns/100ps
// Functional notes
// - no pipelining: one sequence, then its ack
// - pipelining: resources take next sequence immediately
// - pipelining: send without waiting previous ack
// - receiver acknowledges every received sequence
// - delivered only after checked ack change
// - input direction: limit and delay registers
// - output pipelining usable once size set
// - limit register accepts 1..7, resets 1
// - software: limit at most 5 or 7
// - wait delay after send before next write
module seq_fwd_device
    import seq_fwd_pkg::*;
#(
    parameter int BUS_CYC = BUS_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire logic tx_valid,
    input wire logic [DATA_W-1:0] tx_data,
    output logic tx_taken,
    seq_link_if.dev link
);
    // the counters and the limit compare must hold their widest values
    if (BUS_CYC < 4 || BUS_CYC > 65536) begin : g_bad_bus_cyc
        $error("BUS_CYC out of range");
    end
    if (LIMIT_MAX >= (1 << SEQ_W)) begin : g_bad_seq_w
        $error("SEQ_W too narrow for the limit");
    end
    if (DELAY_CNT_W < 16 + $clog2(CYC_PER_US + 1)) begin : g_bad_delay_w
        $error("DELAY_CNT_W too narrow for the delay");
    end

    typedef struct packed {
        logic pipe_en;
        logic [7:0] limit;
        logic [15:0] delay_us;
        logic [7:0] out_mtu;
        logic [15:0] tick_cnt;
        logic [DELAY_CNT_W-1:0] delay_cnt;
        logic [SEQ_W-1:0] outst;
        logic [SEQ_W-1:0] seq_ctr;
        logic [SEQ_W-1:0] ack_seen;
        logic ack_err;
        logic seq_valid;
        logic [DATA_W-1:0] seq_data;
        logic tx_taken;
        logic [31:0] rdata;
    } dev_state_t;

    localparam dev_state_t RST_STATE = '{
        pipe_en: 1'b0,
        limit: LIMIT_RST,
        delay_us: DELAY_RST,
        out_mtu: OUT_MTU_RST,
        tick_cnt: 16'h0000,
        delay_cnt: '0,
        outst: '0,
        seq_ctr: '0,
        ack_seen: '0,
        ack_err: 1'b0,
        seq_valid: 1'b0,
        seq_data: '0,
        tx_taken: 1'b0,
        rdata: 32'h0000_0000
    };

    localparam logic [15:0] TICK_RELOAD = 16'(BUS_CYC - 1);

    dev_state_t q;
    dev_state_t d;

    logic tick;
    logic [SEQ_W-1:0] ack_diff;
    logic [SEQ_W-1:0] limit_eff;
    logic can_send;

    function automatic logic [31:0] status_word(input dev_state_t s);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[STAT_OUTST_LSB +: SEQ_W] = s.outst;
        w[STAT_SEQ_LSB +: SEQ_W] = s.seq_ctr;
        w[STAT_ACK_LSB +: SEQ_W] = s.ack_seen;
        w[STAT_ERR_BIT] = s.ack_err;
        w[STAT_OUT_FWD_BIT] = (s.out_mtu != 8'h00);
        return w;
    endfunction

    always_comb begin
        d = q;
        d.seq_valid = 1'b0;
        d.tx_taken = 1'b0;
        d.rdata = 32'h0000_0000;
        tick = (q.tick_cnt == 16'h0000);
        ack_diff = '0;
        limit_eff = 3'h1;
        can_send = 1'b0;

        // bus cycle pacing
        if (tick) begin
            d.tick_cnt = TICK_RELOAD;
        end else begin
            d.tick_cnt = q.tick_cnt - 16'h0001;
        end
        if (q.delay_cnt != '0) begin
            d.delay_cnt = q.delay_cnt - DELAY_CNT_W'(1);
        end

        // register writes
        if (wr) begin
            case (addr)
                DEV_CTRL_OFS: begin
                    d.pipe_en = wdata[CTRL_PIPE_BIT];
                end
                DEV_LIMIT_OFS: begin
                    if (wdata[7:0] >= LIMIT_MIN &&
                        wdata[7:0] <= LIMIT_MAX) begin
                        d.limit = wdata[7:0];
                    end
                end
                DEV_DELAY_OFS: begin
                    d.delay_us = wdata[15:0];
                end
                DEV_OUT_MTU_OFS: begin
                    d.out_mtu = wdata[7:0];
                end
                DEV_STATUS_OFS: begin
                    if (wdata[STAT_ERR_BIT]) begin
                        d.ack_err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // register reads, data in the next cycle
        if (rd) begin
            case (addr)
                DEV_CTRL_OFS: d.rdata = {31'h0, q.pipe_en};
                DEV_LIMIT_OFS: d.rdata = {24'h0, q.limit};
                DEV_DELAY_OFS: d.rdata = {16'h0, q.delay_us};
                DEV_OUT_MTU_OFS: d.rdata = {24'h0, q.out_mtu};
                DEV_STATUS_OFS: d.rdata = status_word(q);
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // a cumulative ack may retire several sequences at once
        // check changed ack
        if (link.sequence_acknowledge != q.ack_seen) begin
            ack_diff = link.sequence_acknowledge - q.ack_seen;
            if (ack_diff <= q.outst) begin
                d.outst = q.outst - ack_diff;
            end else begin
                // error set wins over a clear in the same cycle
                d.ack_err = 1'b1;
            end
            d.ack_seen = link.sequence_acknowledge;
        end

        if (q.pipe_en) begin
            limit_eff = q.limit[SEQ_W-1:0];
        end

        // delay is only looked at on ticks, so it rounds up to bus cycles
        // stall at limit
        can_send = tick && tx_valid && (q.delay_cnt == '0) &&
                   (d.outst < limit_eff);

        if (can_send) begin
            d.seq_ctr = q.seq_ctr + 3'h1;
            d.seq_data = tx_data;
            d.seq_valid = 1'b1;
            d.tx_taken = 1'b1;
            d.outst = d.outst + 3'h1;
            d.delay_cnt = DELAY_CNT_W'(q.delay_us * CYC_PER_US);
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign tx_taken = q.tx_taken;
    assign link.seq_valid = q.seq_valid;
    assign link.seq_data = q.seq_data;
    assign link.seq_count = q.seq_ctr;
endmodule

// ---- hw/seq_fwd_pkg.sv ----
package seq_fwd_pkg;
    // timing
    localparam int CLK_HZ = 40_000_000;
    localparam int HZ_PER_MHZ = 1_000_000;
    localparam int CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
    localparam int BUS_CYCLE_US = 10;
    localparam int BUS_CYCLE_CYC = BUS_CYCLE_US * CYC_PER_US;
    localparam int DELAY_CNT_W = 22;
    // link widths
    localparam int SEQ_W = 3;
    localparam int DATA_W = 8;
    // device register offsets
    localparam logic [7:0] DEV_CTRL_OFS = 8'h00;
    localparam logic [7:0] DEV_LIMIT_OFS = 8'h04;
    localparam logic [7:0] DEV_DELAY_OFS = 8'h08;
    localparam logic [7:0] DEV_OUT_MTU_OFS = 8'h0C;
    localparam logic [7:0] DEV_STATUS_OFS = 8'h10;
    // device fields and reset values
    localparam int CTRL_PIPE_BIT = 0;
    localparam int STAT_OUTST_LSB = 0;
    localparam int STAT_SEQ_LSB = 4;
    localparam int STAT_ACK_LSB = 8;
    localparam int STAT_ERR_BIT = 12;
    localparam int STAT_OUT_FWD_BIT = 13;
    localparam logic [7:0] LIMIT_RST = 8'h01;
    localparam logic [7:0] LIMIT_MIN = 8'h01;
    localparam logic [7:0] LIMIT_MAX = 8'h07;
    localparam logic [15:0] DELAY_RST = 16'h0000;
    localparam logic [7:0] OUT_MTU_RST = 8'h00;
    // controller register offsets and fields
    localparam logic [7:0] CTL_LAG_OFS = 8'h00;
    localparam logic [7:0] CTL_RXDATA_OFS = 8'h04;
    localparam logic [7:0] CTL_STATUS_OFS = 8'h08;
    localparam int CTL_ERR_BIT = 16;
    localparam int CTL_ACK_LSB = 20;
    localparam logic [15:0] LAG_RST = 16'h0010;
endpackage

// ---- hw/seq_link_if.sv ----
`timescale 1ns/100ps
interface seq_link_if;
    import seq_fwd_pkg::*;
    logic seq_valid;
    logic [DATA_W-1:0] seq_data;
    logic [SEQ_W-1:0] seq_count;
    logic [SEQ_W-1:0] sequence_acknowledge;
    modport dev (
        output seq_valid,
        output seq_data,
        output seq_count,
        input sequence_acknowledge
    );
    modport ctl (
        input seq_valid,
        input seq_data,
        input seq_count,
        output sequence_acknowledge
    );
endinterface

// ---- hw/seq_fwd_controller.sv ----
`timescale 1ns/100ps
module seq_fwd_controller
    import seq_fwd_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    output logic rx_valid,
    output logic [DATA_W-1:0] rx_data,
    seq_link_if.ctl link
);
    typedef struct packed {
        logic [15:0] lag;
        logic [15:0] lag_cnt;
        logic pending;
        logic [SEQ_W-1:0] last_seq;
        logic [SEQ_W-1:0] ack;
        logic [SEQ_W-1:0] expect_seq;
        logic [15:0] rx_cnt;
        logic err;
        logic rx_valid;
        logic [DATA_W-1:0] rx_data;
        logic [31:0] rdata;
    } ctl_state_t;

    localparam ctl_state_t RST_STATE = '{
        lag: LAG_RST,
        lag_cnt: 16'h0000,
        pending: 1'b0,
        last_seq: '0,
        ack: '0,
        expect_seq: 3'h1,
        rx_cnt: 16'h0000,
        err: 1'b0,
        rx_valid: 1'b0,
        rx_data: '0,
        rdata: 32'h0000_0000
    };

    ctl_state_t q;
    ctl_state_t d;

    always_comb begin
        d = q;
        d.rx_valid = 1'b0;
        d.rdata = 32'h0000_0000;

        if (wr) begin
            case (addr)
                CTL_LAG_OFS: d.lag = wdata[15:0];
                CTL_STATUS_OFS: begin
                    if (wdata[CTL_ERR_BIT]) begin
                        d.err = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        if (rd) begin
            case (addr)
                CTL_LAG_OFS: d.rdata = {16'h0, q.lag};
                CTL_RXDATA_OFS: d.rdata = {24'h0, q.rx_data};
                CTL_STATUS_OFS: begin
                    d.rdata = {9'h0, q.ack, 3'h0, q.err, q.rx_cnt};
                end
                default: d.rdata = 32'h0000_0000;
            endcase
        end

        // slow task: ack goes out after the lag, cumulative
        if (q.pending) begin
            if (q.lag_cnt == 16'h0000) begin
                d.ack = q.last_seq;
                d.pending = 1'b0;
            end else begin
                d.lag_cnt = q.lag_cnt - 16'h0001;
            end
        end

        if (link.seq_valid) begin
            d.rx_cnt = q.rx_cnt + 16'h0001;
            d.rx_data = link.seq_data;
            d.rx_valid = 1'b1;
            // a gap in the counter is flagged, set wins over clear
            if (link.seq_count != q.expect_seq) begin
                d.err = 1'b1;
            end
            d.expect_seq = link.seq_count + 3'h1;
            d.last_seq = link.seq_count;
            if (!d.pending) begin
                d.pending = 1'b1;
                d.lag_cnt = q.lag;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= RST_STATE;
        end else begin
            q <= d;
        end
    end

    assign rdata = q.rdata;
    assign rx_valid = q.rx_valid;
    assign rx_data = q.rx_data;
    assign link.sequence_acknowledge = q.ack;
endmodule

// ---- test/seq_fwd_asserts.sv ----
`timescale 1ns/100ps
module seq_fwd_asserts
    import seq_fwd_pkg::*;
#(
    parameter int BUS_CYC = BUS_CYCLE_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic seq_valid,
    input wire logic [DATA_W-1:0] seq_data,
    input wire logic [SEQ_W-1:0] seq_count,
    input wire logic [SEQ_W-1:0] sequence_acknowledge
);
    localparam int ACK_WAIT_MAX = 200;
    int ph_q;
    int gap_q;
    int wait_q;
    logic [SEQ_W-1:0] ak;
    logic [SEQ_W-1:0] ak_q;
    assign ak = sequence_acknowledge;
    // tick phase, spacing since the last send, cycles with no ack move
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_q <= 0;
            gap_q <= 0;
            wait_q <= 0;
            ak_q <= '0;
        end else begin
            ph_q <= (ph_q + 1) % BUS_CYC;
            gap_q <= seq_valid ? 1 : (gap_q == 0 ? 0 : gap_q + 1);
            ak_q <= ak;
            if (ak != ak_q || ak == seq_count) begin
                wait_q <= 0;
            end else begin
                wait_q <= wait_q + 1;
            end
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    send_pulse_a: assert property (seq_valid |=> !seq_valid)
        else $error("send pulse longer than one cycle");
    count_step_a: assert property (
        seq_valid |-> seq_count == $past(seq_count) + 3'h1)
        else $error("sequence counter did not step by one");
    count_hold_a: assert property (
        !seq_valid |-> $stable(seq_count))
        else $error("sequence counter moved without a send");
    data_hold_a: assert property (!seq_valid |-> $stable(seq_data))
        else $error("payload moved without a send");
    tick_phase_a: assert property (seq_valid |-> ph_q == 1)
        else $error("send not aligned to a bus cycle");
    send_gap_a: assert property (
        seq_valid && gap_q != 0 |-> gap_q >= BUS_CYC)
        else $error("two sends within one bus cycle");
    ack_range_a: assert property (!$stable(ak) |->
        ((ak - $past(ak)) & 3'h7) <= ((seq_count - $past(ak)) & 3'h7))
        else $error("ack beyond the last sent sequence");
    // open sequences must see the ack move within a bounded time
    ack_due_a: assert property (wait_q < ACK_WAIT_MAX)
        else $error("sequence not acknowledged in time");
    cover property (seq_valid);
    cover property (seq_valid && ((seq_count - ak) & 3'h7) == 3'h3);
    cover property (!$stable(ak));
endmodule

// ---- test/tb_pipelined_sequence_transmit_window.sv ----
`timescale 1ns/100ps
module tb_pipelined_sequence_transmit_window
    import seq_fwd_pkg::*;
;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] m;
        logic [31:0] e;
    } row_t;
    row_t rows[8] = '{
        '{DEV_LIMIT_OFS, 32'h3, 32'hFF, 32'h3},
        '{DEV_LIMIT_OFS, 32'h0, 32'hFF, 32'h3},
        '{DEV_LIMIT_OFS, 32'h8, 32'hFF, 32'h3},
        '{DEV_LIMIT_OFS, 32'h7, 32'hFF, 32'h7},
        '{DEV_DELAY_OFS, 32'h1234ABCD, 32'hFFFFFFFF, 32'hABCD},
        '{DEV_OUT_MTU_OFS, 32'h40, 32'hFFFFFFFF, 32'h40},
        '{DEV_STATUS_OFS, 32'h0, 32'h2000, 32'h2000},
        '{8'h20, 32'h5A, 32'hFFFFFFFF, 32'h0}};
    logic clk, rst, dwr, drd, cwr, crd, tx_valid, tx_taken, rx_valid;
    logic [7:0] addr, tx_data, rx_data, exp_rx;
    logic [31:0] wdata, drdata, crdata, v, max_fl, min_gap, gap;
    logic [2:0] fl_now;
    int failures = 0, n_compared = 0, n_sent, n_goal, i;
    seq_link_if lk();
    seq_fwd_device #(.BUS_CYC(8)) i_seq_fwd_device(.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(dwr), .rd(drd), .rdata(drdata),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_taken(tx_taken),
        .link(lk.dev));
    seq_fwd_controller i_seq_fwd_controller(.clk(clk), .rst(rst),
        .addr(addr), .wdata(wdata), .wr(cwr), .rd(crd), .rdata(crdata),
        .rx_valid(rx_valid), .rx_data(rx_data), .link(lk.ctl));
    seq_fwd_asserts #(.BUS_CYC(8)) i_seq_fwd_asserts(.clk(clk), .rst(rst),
        .seq_valid(lk.seq_valid), .seq_data(lk.seq_data),
        .seq_count(lk.seq_count),
        .sequence_acknowledge(lk.sequence_acknowledge));
    assign fl_now = lk.seq_count - lk.sequence_acknowledge;
    always #12.5 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
            failures++;
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic reg_wr(input logic c, input logic [7:0] a,
                          input logic [31:0] d);
        addr <= a;
        wdata <= d;
        dwr <= !c;
        cwr <= c;
        @(posedge clk);
        dwr <= 1'b0;
        cwr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic reg_rd(input logic c, input logic [7:0] a);
        addr <= a;
        drd <= !c;
        crd <= c;
        @(posedge clk);
        drd <= 1'b0;
        crd <= 1'b0;
        @(posedge clk);
        v = c ? crdata : drdata;
    endtask
    // configure both ends, push n bytes and wait for the last ack
    task automatic run(input logic p, input logic [7:0] lim,
                       input logic [15:0] dly, input logic [15:0] lag,
                       input int n);
        int k;
        reg_wr(1'b0, DEV_CTRL_OFS, {31'h0, p});
        reg_wr(1'b0, DEV_LIMIT_OFS, {24'h0, lim});
        reg_wr(1'b0, DEV_DELAY_OFS, {16'h0, dly});
        reg_wr(1'b1, CTL_LAG_OFS, {16'h0, lag});
        max_fl = 0;
        min_gap = 32'hFFFF;
        n_goal = n;
        n_sent = 0;
        tx_valid <= 1'b1;
        for (k = 0; k < 4000 && n_sent < n; k++) @(posedge clk);
        for (k = 0; k < 300 && fl_now !== 3'h0; k++) @(posedge clk);
        if (n_sent < n || fl_now !== 3'h0) begin
            failures++;
            end_of_test();
        end
        reg_rd(1'b0, DEV_STATUS_OFS);
        chk(v & 32'h1007, 32'h0);
    endtask
    // source drops its offer once the last byte is taken
    always @(posedge clk) begin
        if (tx_taken) begin
            tx_data <= tx_data + 8'h01;
            n_sent <= n_sent + 1;
            if (n_sent + 1 >= n_goal) tx_valid <= 1'b0;
        end
        if (rx_valid) begin
            chk({24'h0, rx_data}, {24'h0, exp_rx});
            exp_rx <= exp_rx + 8'h01;
        end
        if ({29'h0, fl_now} > max_fl) max_fl <= {29'h0, fl_now};
        if (lk.seq_valid && gap != 0 && gap < min_gap) min_gap <= gap;
        gap <= lk.seq_valid ? 32'h1 : gap + 32'h1;
    end
    initial begin
        {clk, dwr, drd, cwr, crd, tx_valid} = '0;
        {addr, wdata, tx_data, exp_rx, gap} = '0;
        rst = 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (i = 0; i < 8; i++) begin
            reg_wr(1'b0, rows[i].a, rows[i].d);
            reg_rd(1'b0, rows[i].a);
            chk(v & rows[i].m, rows[i].e);
        end
        // second reset in mid-run must restore the defaults
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        reg_rd(1'b0, DEV_LIMIT_OFS);
        chk(v, 32'h1);
        reg_rd(1'b0, DEV_CTRL_OFS);
        chk(v, 32'h0);
        reg_rd(1'b1, CTL_LAG_OFS);
        chk(v, {16'h0, LAG_RST});
        run(1'b0, 8'h7, 16'h0, 16'h1E, 4);
        chk(max_fl, 32'h1);
        run(1'b1, 8'h3, 16'h0, 16'h1E, 7);
        chk(max_fl, 32'h3);
        run(1'b1, 8'h7, 16'h1, 16'h0, 3);
        chk({31'h0, min_gap >= 32'h28}, 32'h1);
        // 14 sequences since reset, counter at 6, all acknowledged
        reg_rd(1'b0, DEV_STATUS_OFS);
        chk(v, 32'h0000_0660);
        reg_rd(1'b1, CTL_STATUS_OFS);
        chk(v, 32'h0060_000E);
        end_of_test();
    end
endmodule
